// File: core/netrm_top.sv
// Receive-condition-B mask, noise threshold registers and noise timer.
// Assumes line state and condition flags arrive synchronous to clk_i.
// Contract
// - Summary B is set one clock after any condition-B flag and its mask bit are both 1.
// - Reset clears the condition-B mask so all events start masked.
// - Mask bits 0..7 are idle, threshold, active, unknown, cascade, buffer, super idle, spare.
// - In noise states the noise count drops by one per prescale expiry.
// - A zero prescale count reloads from its threshold and decrements the noise count.
// - Both counters reload together when both are zero in a noise, active or unknown state.
// - Both counters are held at their thresholds in halt, idle, master, quiet or no signal.
// - A write to either threshold register loads both counters at once.
// - Entering noise, active or unknown keeps the counters running from where they are.
// - Both counters reaching zero sets the noise threshold flag of condition register A.
// - Noise threshold holds 7 bits; bit 7 reads 0 and ignores writes.
// - Prescale threshold holds 8 bits, bit 0 the least significant.
// - The noise flag feeds summary A only while mask A bit 5 is set.
`timescale 1ns/1ps
module netrm_top #(
	parameter int NOISE_BITS = netrm_pkg::NOISE_W,
	parameter int PRESCALE_BITS = netrm_pkg::PRESCALE_W
) (
	input wire logic clk_i,
	input wire logic resetn_i,
	input wire netrm_pkg::netrm_cb_req_t cb_req_i,
	output logic [7:0] cb_rdata_o,
	input wire netrm_pkg::netrm_line_state_t line_state_i,
	input wire logic [7:0] rx_cond_b_flags_i,
	output logic rx_cond_b_summary_o,
	input wire logic [7:0] rx_cond_a_mask_i,
	input wire logic noise_expired_flag_i,
	output logic noise_expired_set_o,
	output logic noise_summary_term_o,
	output logic [NOISE_BITS-1:0] noise_count_o,
	output logic [PRESCALE_BITS-1:0] prescale_count_o
);
	// ==========================================================
	// Line state decode
	function automatic logic ls_holds(input netrm_pkg::netrm_line_state_t ls);
		case (ls)
			netrm_pkg::LS_HALT,
			netrm_pkg::LS_IDLE,
			netrm_pkg::LS_MASTER,
			netrm_pkg::LS_QUIET,
			netrm_pkg::LS_NO_SIGNAL: ls_holds = 1'b1;
			default: ls_holds = 1'b0;
		endcase
	endfunction : ls_holds

	logic [7:0] mask_r;
	logic [7:0] mask_nxt;
	logic [NOISE_BITS-1:0] noise_thr_r;
	logic [NOISE_BITS-1:0] noise_thr_nxt;
	logic [PRESCALE_BITS-1:0] pre_thr_r;
	logic [PRESCALE_BITS-1:0] pre_thr_nxt;
	logic [7:0] rdata_r;
	logic [7:0] rdata_nxt;
	logic summary_r;
	logic summary_nxt;
	logic expire_r;
	logic expire_nxt;
	logic tick;
	logic hold;
	logic run;
	logic wr_noise;
	logic wr_pre;
	logic wr_mask;
	logic load_all;
	logic pre_load;
	logic pre_dec;
	logic noise_dec;
	logic noise_zero;
	logic pre_zero;
	logic [NOISE_BITS-1:0] noise_cnt;
	logic [PRESCALE_BITS-1:0] pre_cnt;
	logic [NOISE_BITS-1:0] noise_expect;
	logic [PRESCALE_BITS-1:0] pre_expect;

	// ==========================================================
	// Write strobes
	assign wr_mask = cb_req_i.wr && (cb_req_i.addr == netrm_pkg::ADDR_RX_COND_B_MASK);
	assign wr_noise = cb_req_i.wr && (cb_req_i.addr == netrm_pkg::ADDR_NOISE_THRESHOLD);
	assign wr_pre = cb_req_i.wr && (cb_req_i.addr == netrm_pkg::ADDR_NOISE_PRESCALE);

	// ==========================================================
	// Register file next values
	always_comb begin
		mask_nxt = mask_r;
		noise_thr_nxt = noise_thr_r;
		pre_thr_nxt = pre_thr_r;
		if (wr_mask) begin
			mask_nxt = cb_req_i.wdata;
		end
		if (wr_noise) begin
			noise_thr_nxt = cb_req_i.wdata[NOISE_BITS-1:0];
		end
		if (wr_pre) begin
			pre_thr_nxt = cb_req_i.wdata[PRESCALE_BITS-1:0];
		end
	end

	// Read data is registered; unmapped addresses read as zero
	always_comb begin
		rdata_nxt = netrm_pkg::RDATA_IDLE;
		if (cb_req_i.rd) begin
			case (cb_req_i.addr)
				netrm_pkg::ADDR_RX_COND_B_MASK: rdata_nxt = mask_r;
				netrm_pkg::ADDR_NOISE_THRESHOLD: begin
					rdata_nxt = 8'(noise_thr_r) & netrm_pkg::NOISE_THR_FIELD;
				end
				netrm_pkg::ADDR_NOISE_PRESCALE: rdata_nxt = 8'(pre_thr_r);
				default: rdata_nxt = netrm_pkg::RDATA_IDLE;
			endcase
		end
	end

	// Thresholds have no documented reset; zero keeps them defined
	always_ff @(posedge clk_i) begin
		if (!resetn_i) begin
			mask_r <= netrm_pkg::MASK_RST;
			noise_thr_r <= NOISE_BITS'(netrm_pkg::NOISE_THR_RST);
			pre_thr_r <= PRESCALE_BITS'(netrm_pkg::PRESCALE_THR_RST);
			rdata_r <= netrm_pkg::RDATA_IDLE;
		end else begin
			mask_r <= mask_nxt;
			noise_thr_r <= noise_thr_nxt;
			pre_thr_r <= pre_thr_nxt;
			rdata_r <= rdata_nxt;
		end
	end

	assign cb_rdata_o = rdata_r;

	// ==========================================================
	// Condition-B summary and noise contribution to summary A
	always_comb begin
		summary_nxt = |(rx_cond_b_flags_i & mask_r);
	end

	assign noise_summary_term_o = noise_expired_flag_i &&
		rx_cond_a_mask_i[netrm_pkg::NOISE_MASK_BIT];

	// ==========================================================
	// Noise timer control
	netrm_tick #(
		.CYCLES(netrm_pkg::TICK_CYCLES)
	) u_tick (
		.clk_i(clk_i),
		.resetn_i(resetn_i),
		.tick_o(tick)
	);

	// Hold states keep reloading; a state change alone never reloads
	assign hold = ls_holds(line_state_i);
	assign run = !hold;
	// Threshold writes act at once, not on the next tick
	assign load_all = hold || wr_noise || wr_pre ||
		(tick && run && pre_zero && noise_zero);
	assign pre_load = load_all || (tick && run && pre_zero);
	assign pre_dec = tick && run && !pre_zero;
	assign noise_dec = !load_all && tick && run && pre_zero;

	netrm_dcount #(
		.W(PRESCALE_BITS)
	) u_prescale (
		.clk_i(clk_i),
		.resetn_i(resetn_i),
		.load_i(pre_load),
		.load_val_i(pre_thr_nxt),
		.dec_i(pre_dec),
		.value_o(pre_cnt),
		.zero_o(pre_zero)
	);

	netrm_dcount #(
		.W(NOISE_BITS)
	) u_noise (
		.clk_i(clk_i),
		.resetn_i(resetn_i),
		.load_i(load_all),
		.load_val_i(noise_thr_nxt),
		.dec_i(noise_dec),
		.value_o(noise_cnt),
		.zero_o(noise_zero)
	);

	// Expiry is flagged when the counting itself lands on zero/zero
	always_comb begin
		noise_expect = noise_dec ? noise_cnt - NOISE_BITS'(1) : noise_cnt;
		pre_expect = pre_load ? pre_thr_nxt : pre_cnt - PRESCALE_BITS'(1);
		expire_nxt = !load_all && tick && run &&
			(noise_expect == '0) && (pre_expect == '0);
	end

	always_ff @(posedge clk_i) begin
		if (!resetn_i) begin
			summary_r <= 1'b0;
			expire_r <= 1'b0;
		end else begin
			summary_r <= summary_nxt;
			expire_r <= expire_nxt;
		end
	end

	assign rx_cond_b_summary_o = summary_r;
	assign noise_expired_set_o = expire_r;
	assign noise_count_o = noise_cnt;
	assign prescale_count_o = pre_cnt;

	// ==========================================================
	// Checks
	property p_summary;
		@(posedge clk_i) disable iff (!resetn_i)
		(|(rx_cond_b_flags_i & mask_r)) |=> rx_cond_b_summary_o;
	endproperty
	a_summary: assert property (p_summary) else $error("summary B missed");

	property p_mask_reset;
		@(posedge clk_i) !resetn_i |=> (mask_r == netrm_pkg::MASK_RST);
	endproperty
	a_mask_reset: assert property (p_mask_reset) else $error("mask not cleared");

	property p_mask_write;
		@(posedge clk_i) disable iff (!resetn_i)
		wr_mask |=> (mask_r == $past(cb_req_i.wdata));
	endproperty
	a_mask_write: assert property (p_mask_write) else $error("mask write lost");

	property p_noise_dec;
		@(posedge clk_i) disable iff (!resetn_i)
		(tick && run && pre_zero && !noise_zero && !cb_req_i.wr) |=>
		(noise_cnt == $past(noise_cnt) - NOISE_BITS'(1)) && (pre_cnt == pre_thr_r);
	endproperty
	a_noise_dec: assert property (p_noise_dec) else $error("noise step wrong");

	property p_pre_dec;
		@(posedge clk_i) disable iff (!resetn_i)
		(tick && run && !pre_zero && !cb_req_i.wr) |=>
		(pre_cnt == $past(pre_cnt) - PRESCALE_BITS'(1)) && $stable(noise_cnt);
	endproperty
	a_pre_dec: assert property (p_pre_dec) else $error("prescale step wrong");

	property p_wrap;
		@(posedge clk_i) disable iff (!resetn_i)
		(tick && run && pre_zero && noise_zero) |=>
		(noise_cnt == noise_thr_r) && (pre_cnt == pre_thr_r);
	endproperty
	a_wrap: assert property (p_wrap) else $error("zero reload missed");

	property p_hold;
		@(posedge clk_i) disable iff (!resetn_i)
		hold |=> (noise_cnt == noise_thr_r) && (pre_cnt == pre_thr_r);
	endproperty
	a_hold: assert property (p_hold) else $error("hold reload missed");

	property p_thr_write;
		@(posedge clk_i) disable iff (!resetn_i)
		wr_noise |=> (noise_cnt == $past(cb_req_i.wdata[NOISE_BITS-1:0]))
		&& (pre_cnt == pre_thr_r);
	endproperty
	a_thr_write: assert property (p_thr_write) else $error("write load missed");

	property p_keep;
		@(posedge clk_i) disable iff (!resetn_i)
		(run && !tick && !cb_req_i.wr) |=> $stable(noise_cnt) && $stable(pre_cnt);
	endproperty
	a_keep: assert property (p_keep) else $error("counters moved");

	property p_expire;
		@(posedge clk_i) disable iff (!resetn_i)
		noise_expired_set_o |-> (noise_cnt == '0) && (pre_cnt == '0) && !$past(hold);
	endproperty
	a_expire: assert property (p_expire) else $error("bad expiry");

	property p_rd_noise;
		@(posedge clk_i) disable iff (!resetn_i)
		(cb_req_i.rd && cb_req_i.addr == netrm_pkg::ADDR_NOISE_THRESHOLD) |=>
		(cb_rdata_o[7] == 1'b0) && (cb_rdata_o[6:0] == 7'($past(noise_thr_r)));
	endproperty
	a_rd_noise: assert property (p_rd_noise) else $error("threshold read wrong");

	property p_rd_pre;
		@(posedge clk_i) disable iff (!resetn_i)
		(cb_req_i.rd && cb_req_i.addr == netrm_pkg::ADDR_NOISE_PRESCALE) |=>
		(cb_rdata_o == 8'($past(pre_thr_r)));
	endproperty
	a_rd_pre: assert property (p_rd_pre) else $error("prescale read wrong");

	property p_term;
		@(posedge clk_i) disable iff (!resetn_i)
		!rx_cond_a_mask_i[netrm_pkg::NOISE_MASK_BIT] |-> !noise_summary_term_o;
	endproperty
	a_term: assert property (p_term) else $error("masked noise leaked");

	property p_tick;
		@(posedge clk_i) disable iff (!resetn_i)
		tick |=> !tick;
	endproperty
	a_tick: assert property (p_tick) else $error("tick too long");
endmodule : netrm_top

// File: core/netrm_pkg.sv
// Constants, types and register map of the noise event timer block.
// Assumes one 25 MHz clock and the byte-wide control bus port.
package netrm_pkg;
	// ==========================================================
	// Register map
	localparam logic [7:0] ADDR_RX_COND_B_MASK = 8'h0C;
	localparam logic [7:0] ADDR_NOISE_THRESHOLD = 8'h0D;
	localparam logic [7:0] ADDR_NOISE_PRESCALE = 8'h0E;
	localparam logic [7:0] MASK_RST = 8'h00;
	localparam logic [6:0] NOISE_THR_RST = 7'h00;
	localparam logic [7:0] PRESCALE_THR_RST = 8'h00;
	localparam logic [7:0] RDATA_IDLE = 8'h00;
	localparam logic [7:0] NOISE_THR_FIELD = 8'h7F;
	localparam int NOISE_W = 7;
	localparam int PRESCALE_W = 8;
	localparam int NOISE_MASK_BIT = 5;
	// ==========================================================
	// Mask register bit positions
	localparam int IDLE_STATE_MASK_BIT = 0;
	localparam int STATE_THRESHOLD_MASK_BIT = 1;
	localparam int ACTIVE_STATE_MASK_BIT = 2;
	localparam int UNKNOWN_VALID_MASK_BIT = 3;
	localparam int CASCADE_ERROR_MASK_BIT = 4;
	localparam int ELASTIC_BUFFER_ERR_MASK_BIT = 5;
	localparam int SUPER_IDLE_MASK_BIT = 6;
	localparam int RESERVED_MASK_BIT = 7;
	// ==========================================================
	// Timing
	localparam int CLK_PERIOD_NS = 40;
	localparam int TICK_PERIOD_NS = 80;
	localparam int TICK_CYCLES = (TICK_PERIOD_NS / CLK_PERIOD_NS < 1) ? 1 :
		TICK_PERIOD_NS / CLK_PERIOD_NS;
	// ==========================================================
	// Types
	typedef enum logic [2:0] {
		LS_QUIET,
		LS_IDLE,
		LS_MASTER,
		LS_HALT,
		LS_ACTIVE,
		LS_NOISE,
		LS_UNKNOWN,
		LS_NO_SIGNAL
	} netrm_line_state_t;

	typedef struct packed {
		logic wr;
		logic rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} netrm_cb_req_t;
endpackage : netrm_pkg

// File: core/netrm_tick.sv
// Single-cycle tick every TICK period of the symbol clock.
// Assumes a free-running clk_i.
`timescale 1ns/1ps
module netrm_tick #(
	parameter int CYCLES = netrm_pkg::TICK_CYCLES
) (
	input wire logic clk_i,
	input wire logic resetn_i,
	output logic tick_o
);
	localparam int CW = (CYCLES > 1) ? $clog2(CYCLES) : 1;
	localparam logic [CW-1:0] LAST = CW'(CYCLES - 1);
	logic [CW-1:0] cnt_r;
	logic [CW-1:0] cnt_nxt;

	// ==========================================================
	// Divider: tick on the last count
	always_comb begin
		cnt_nxt = (cnt_r == LAST) ? '0 : cnt_r + CW'(1);
	end

	always_ff @(posedge clk_i) begin
		if (!resetn_i) begin
			cnt_r <= '0;
		end else begin
			cnt_r <= cnt_nxt;
		end
	end

	assign tick_o = resetn_i && (cnt_r == LAST);
endmodule : netrm_tick

// File: core/netrm_dcount.sv
// Loadable down counter; load wins over decrement.
// Assumes the caller never decrements a zero count.
`timescale 1ns/1ps
module netrm_dcount #(
	parameter int W = 8
) (
	input wire logic clk_i,
	input wire logic resetn_i,
	input wire logic load_i,
	input wire logic [W-1:0] load_val_i,
	input wire logic dec_i,
	output logic [W-1:0] value_o,
	output logic zero_o
);
	logic [W-1:0] val_r;
	logic [W-1:0] val_nxt;

	// ==========================================================
	// Next count
	always_comb begin
		val_nxt = val_r;
		if (load_i) begin
			val_nxt = load_val_i;
		end else if (dec_i) begin
			val_nxt = val_r - W'(1);
		end
	end

	always_ff @(posedge clk_i) begin
		if (!resetn_i) begin
			val_r <= '0;
		end else begin
			val_r <= val_nxt;
		end
	end

	assign value_o = val_r;
	assign zero_o = (val_r == '0);
endmodule : netrm_dcount

// File: testbench/netrm_cb_host.sv
// Control bus host model standing in for the station management processor.
// Assumes the block takes one request per rising clock edge.
`timescale 1ns/1ps
module netrm_cb_host (
	input wire logic clk_i,
	input wire logic [7:0] cb_rdata_i,
	output netrm_pkg::netrm_cb_req_t cb_req_o
);
	// ==========================================================
	// Bus cycles
	// Idle bus carries no strobe, so nothing stale is taken
	initial cb_req_o = '0;

	// One-cycle write strobe, released on the edge that takes it
	task automatic write_reg(input logic [7:0] addr, input logic [7:0] data);
		@(posedge clk_i);
		cb_req_o <= '{wr: 1'b1, rd: 1'b0, addr: addr, wdata: data};
		@(posedge clk_i);
		cb_req_o <= '0;
	endtask : write_reg

	// Read data is registered, so it is taken just after the strobe edge
	task automatic read_reg(input logic [7:0] addr, output logic [7:0] data);
		@(posedge clk_i);
		cb_req_o <= '{wr: 1'b0, rd: 1'b1, addr: addr, wdata: 8'h00};
		@(posedge clk_i);
		cb_req_o <= '0;
		#1;
		data = cb_rdata_i;
	endtask : read_reg

	// Standard noise limit set up by management software
	task automatic program_standard();
		write_reg(8'h0D, 8'h40);
		write_reg(8'h0E, 8'hF9);
	endtask : program_standard
endmodule : netrm_cb_host

// File: testbench/tb_noise_event_timer_rx_mask.sv
// Self-checking bench for the noise timer and condition-B mask block.
// Assumes a 25 MHz clock and the host model on the control bus.
`timescale 1ns/1ps
module tb_noise_event_timer_rx_mask;
	logic clk_i = 1'b0;
	logic resetn_i = 1'b0;
	netrm_pkg::netrm_line_state_t line_state = netrm_pkg::LS_IDLE;
	logic [7:0] flags_b = 8'h00;
	logic [7:0] mask_a = 8'h00;
	logic noise_flag = 1'b0;
	netrm_pkg::netrm_cb_req_t cb_req;
	logic [7:0] cb_rdata;
	logic summary_b;
	logic exp_set;
	logic summary_term;
	logic [6:0] noise_cnt;
	logic [7:0] pre_cnt;
	logic [7:0] rd;
	int miscompares = 0;
	int tests_run = 0;
	int cyc;
	netrm_pkg::netrm_line_state_t holds [5] = '{netrm_pkg::LS_HALT, netrm_pkg::LS_IDLE,
		netrm_pkg::LS_MASTER, netrm_pkg::LS_QUIET, netrm_pkg::LS_NO_SIGNAL};

	netrm_top u_netrm_top (
		.clk_i(clk_i),
		.resetn_i(resetn_i),
		.cb_req_i(cb_req),
		.cb_rdata_o(cb_rdata),
		.line_state_i(line_state),
		.rx_cond_b_flags_i(flags_b),
		.rx_cond_b_summary_o(summary_b),
		.rx_cond_a_mask_i(mask_a),
		.noise_expired_flag_i(noise_flag),
		.noise_expired_set_o(exp_set),
		.noise_summary_term_o(summary_term),
		.noise_count_o(noise_cnt),
		.prescale_count_o(pre_cnt)
	);

	netrm_cb_host u_netrm_cb_host (
		.clk_i(clk_i),
		.cb_rdata_i(cb_rdata),
		.cb_req_o(cb_req)
	);

	// ==========================================================
	// Clock and shared tasks
	initial begin
		forever #20 clk_i = ~clk_i;
	end

	task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
		tests_run++;
		if (seen !== exp) begin
			miscompares++;
			$display("Error %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	// Lets the given number of edges pass, then settles past the edge
	task automatic edges(input int n);
		repeat (n) @(posedge clk_i);
		#1;
	endtask : edges

	task automatic set_line(input netrm_pkg::netrm_line_state_t ls);
		@(posedge clk_i);
		line_state <= ls;
	endtask : set_line

	task automatic print_verdict();
		$display("Checks %0d, mismatches %0d", tests_run, miscompares);
		if (miscompares == 0 && tests_run > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask : print_verdict

	// ==========================================================
	// Scenarios
	task automatic test_reset();
		u_netrm_cb_host.read_reg(8'h0C, rd);
		check("mask reset", rd, 8'h00);
		// Every flag raised: a cleared mask must still keep the summary low
		@(posedge clk_i);
		flags_b <= 8'hFF;
		edges(2);
		check("summary b masked", summary_b, 1'b0);
		@(posedge clk_i);
		flags_b <= 8'h00;
		$display("test reset done");
	endtask : test_reset

	// Spare bit of the noise threshold and unmapped places refuse data
	task automatic test_regs();
		u_netrm_cb_host.write_reg(8'h0D, 8'hC5);
		u_netrm_cb_host.read_reg(8'h0D, rd);
		check("noise threshold", rd, 8'h45);
		u_netrm_cb_host.write_reg(8'h0E, 8'hA5);
		u_netrm_cb_host.read_reg(8'h0E, rd);
		check("prescale threshold", rd, 8'hA5);
		u_netrm_cb_host.write_reg(8'h13, 8'h55);
		u_netrm_cb_host.read_reg(8'h13, rd);
		check("unmapped read", rd, 8'h00);
		u_netrm_cb_host.program_standard();
		u_netrm_cb_host.read_reg(8'h0D, rd);
		check("standard noise", rd, 8'h40);
		u_netrm_cb_host.read_reg(8'h0E, rd);
		check("standard prescale", rd, 8'hF9);
		$display("test registers done");
	endtask : test_regs

	// Walk one mask bit against its own flag and all the others
	task automatic test_mask();
		for (int i = 0; i < 8; i++) begin
			u_netrm_cb_host.write_reg(8'h0C, 8'h01 << i);
			u_netrm_cb_host.read_reg(8'h0C, rd);
			check("mask readback", rd, 8'h01 << i);
			@(posedge clk_i);
			flags_b <= ~(8'h01 << i);
			edges(2);
			check("summary b other bits", summary_b, 1'b0);
			@(posedge clk_i);
			flags_b <= 8'h01 << i;
			edges(2);
			check("summary b own bit", summary_b, 1'b1);
		end
		@(posedge clk_i);
		flags_b <= 8'h00;
		$display("test mask done");
	endtask : test_mask

	// Count a while, then every hold state must bring back the thresholds
	task automatic test_hold();
		u_netrm_cb_host.write_reg(8'h0D, 8'h03);
		u_netrm_cb_host.write_reg(8'h0E, 8'h02);
		foreach (holds[i]) begin
			set_line(netrm_pkg::LS_NOISE);
			edges(6);
			set_line(holds[i]);
			edges(2);
			check("hold noise count", noise_cnt, 8'h03);
			check("hold prescale count", pre_cnt, 8'h02);
		end
		$display("test hold done");
	endtask : test_hold

	// Smallest thresholds: expiry after three 80 ns ticks, then reload
	task automatic test_expiry();
		u_netrm_cb_host.write_reg(8'h0D, 8'h01);
		u_netrm_cb_host.write_reg(8'h0E, 8'h01);
		set_line(netrm_pkg::LS_NOISE);
		cyc = 0;
		while (exp_set !== 1'b1 && cyc < 20) begin
			edges(1);
			cyc++;
		end
		check("expiry delay", 8'(cyc >= 5 && cyc <= 7), 8'h01);
		check("expiry noise count", noise_cnt, 8'h00);
		check("expiry prescale count", pre_cnt, 8'h00);
		edges(2);
		check("reload noise count", noise_cnt, 8'h01);
		check("reload prescale count", pre_cnt, 8'h01);
		check("expiry pulse ends", exp_set, 1'b0);
		$display("test expiry done");
	endtask : test_expiry

	// Write in a counting state loads at once; counting states do not reload
	task automatic test_keep();
		u_netrm_cb_host.write_reg(8'h0D, 8'h05);
		#1;
		check("write load noise", noise_cnt, 8'h05);
		u_netrm_cb_host.write_reg(8'h0E, 8'h03);
		#1;
		check("write load prescale", pre_cnt, 8'h03);
		edges(9);
		set_line(netrm_pkg::LS_ACTIVE);
		edges(1);
		check("active keeps count", 8'(noise_cnt < 7'h05), 8'h01);
		set_line(netrm_pkg::LS_UNKNOWN);
		edges(1);
		check("unknown keeps count", 8'(noise_cnt < 7'h05), 8'h01);
		set_line(netrm_pkg::LS_IDLE);
		$display("test keep done");
	endtask : test_keep

	task automatic test_summary_a();
		@(posedge clk_i);
		noise_flag <= 1'b1;
		mask_a <= 8'h20;
		edges(1);
		check("noise term masked in", summary_term, 1'b1);
		@(posedge clk_i);
		mask_a <= 8'hDF;
		edges(1);
		check("noise term masked out", summary_term, 1'b0);
		@(posedge clk_i);
		noise_flag <= 1'b0;
		mask_a <= 8'hFF;
		edges(1);
		check("noise term no flag", summary_term, 1'b0);
		$display("test summary a done");
	endtask : test_summary_a

	// A reset in mid-run must clear the mask and prescale threshold once more
	task automatic test_mid_reset();
		u_netrm_cb_host.write_reg(8'h0C, 8'hFF);
		@(posedge clk_i);
		resetn_i <= 1'b0;
		repeat (2) @(posedge clk_i);
		resetn_i <= 1'b1;
		u_netrm_cb_host.read_reg(8'h0C, rd);
		check("mask mid reset", rd, 8'h00);
		u_netrm_cb_host.read_reg(8'h0E, rd);
		check("prescale mid reset", rd, 8'h00);
		check("no expiry from load", exp_set, 1'b0);
		$display("test mid reset done");
	endtask : test_mid_reset

	// ==========================================================
	// Main sequence and watchdog
	initial begin
		repeat (20) @(posedge clk_i);
		resetn_i <= 1'b1;
		test_reset();
		test_regs();
		test_mask();
		test_hold();
		test_expiry();
		test_keep();
		test_summary_a();
		test_mid_reset();
		print_verdict();
	end

	// The whole run needs well under a thousand cycles
	initial begin
		repeat (5000) @(posedge clk_i);
		miscompares++;
		print_verdict();
	end
endmodule : tb_noise_event_timer_rx_mask
